// [hw/twm_consts.svh]
// Constants of the two-wire write master
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH
`define TWM_SYS_CLK_HZ 40000000
`define TWM_SCL_HZ 160000
`define TWM_SCL_MAX_HZ 400000
// Four phases per serial clock period
`define TWM_QUARTER_CYC ((`TWM_SYS_CLK_HZ + 4 * `TWM_SCL_HZ - 1) / (4 * `TWM_SCL_HZ))
`define TWM_MIN_PERIOD_CYC ((`TWM_SYS_CLK_HZ + `TWM_SCL_MAX_HZ - 1) / `TWM_SCL_MAX_HZ)
`define TWM_ADDR_W 7
`define TWM_DIR_WRITE 1'h0
`define TWM_BIT_LAST 4'h8
`endif

// [hw/twm_pkg.sv]
// Types of the two-wire write master
package twm_pkg;
   typedef enum logic [2:0] {
      TWM_IDLE  = 3'b000,
      TWM_START = 3'b001,
      TWM_BIT   = 3'b010,
      TWM_STOP  = 3'b011
   } twm_state_type;
endpackage

// [hw/twm_tick_if.sv]
// Phase tick carrier between divider and master
`timescale 1ns/100ps
interface twm_tick_if;
   logic run;
   logic tick;
   modport gen (input run, output tick);
   modport use_side (output run, input tick);
endinterface

// [hw/twm_divider.sv]
// Quarter-period tick divider for the serial clock
`timescale 1ns/100ps
`include "twm_consts.svh"
module twm_divider (
   // Clocking
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Tick
   twm_tick_if.gen tk
);
   localparam int unsigned QCYC = `TWM_QUARTER_CYC;
   logic [7:0] count;

   // One tick every quarter of the serial clock period
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !tk.run) begin
         count <= 8'h00;
      end else if (clk_en) begin
         if (count == 8'(QCYC - 1)) begin
            count <= 8'h00;
         end else begin
            count <= count + 8'h01;
         end
      end
   end

   assign tk.tick = clk_en && tk.run && (count == 8'(QCYC - 1));
endmodule // twm_divider

// [hw/twm_master.sv]
// Two-wire write master: start, address, data bytes, acknowledge check, stop
// Function
// - Both lines rest released high while no transfer runs.
// - Start: data falls while clock is high.
// - Every transfer ends with stop: data rises while clock is high.
// - Data line changes only while clock is low, except start and stop.
// - Data held stable during clock high; bit taken then.
// - Master releases data on ninth clock and samples acknowledge.
// - This master never drives an acknowledge bit.
// - Address byte follows start, most significant bit first.
// - Address byte low bit carries direction, always write here.
// - Seven-bit address sits above the direction bit.
// - Any number of data bytes follow, each eight bits plus ack clock.
// - Master starts, clocks, addresses and ends every transfer.
// - Serial clock near 160 kHz divided from system clock.
// - Serial clock never exceeds 400 kHz fast mode limit.
// - Acknowledge of each byte is checked for errors.
`timescale 1ns/100ps
`include "twm_consts.svh"
module twm_master (
   // Clocking
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Request side
   input wire logic start_req,
   input wire logic [6:0] slave_addr,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_last,
   output logic tx_ready,
   output logic busy,
   output logic ack_error,
   input wire logic error_clear,
   // Serial clock pin
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   // Serial data pin
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   twm_pkg::twm_state_type state;
   twm_tick_if tk ();
   logic [1:0] phase;
   logic [3:0] bit_idx;
   logic [7:0] shreg;
   logic more;
   logic scl_low;
   logic sda_low;
   logic [2:0] sda_sync;
   logic sda_seen;
   logic got_nack;

   twm_divider u_div (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .tk(tk)
   );

   assign tk.run = (state != twm_pkg::TWM_IDLE);
   wire step = tk.tick;

   // Three-stage sampler; change counts when stages two and three agree
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sda_sync <= 3'h7;
         sda_seen <= 1'b1;
      end else if (clk_en) begin
         sda_sync <= {sda_sync[1:0], sda_in};
         if (sda_sync[1] == sda_sync[2]) begin
            sda_seen <= sda_sync[2];
         end
      end
   end

   // Bit sequencing: phase 0 low/setup, 1 rise, 2 high/sample, 3 fall
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= twm_pkg::TWM_IDLE;
         phase <= 2'h0;
         bit_idx <= 4'h0;
         shreg <= 8'h00;
         more <= 1'b0;
         got_nack <= 1'b0;
      end else if (clk_en) begin
         got_nack <= 1'b0;
         case (state)
            twm_pkg::TWM_IDLE: begin
               phase <= 2'h0;
               if (start_req) begin
                  state <= twm_pkg::TWM_START;
                  shreg <= {slave_addr, `TWM_DIR_WRITE};
                  more <= 1'b1;
               end
            end
            twm_pkg::TWM_START: begin
               if (step) begin
                  phase <= phase + 2'h1;
                  if (phase == 2'h1) begin
                     state <= twm_pkg::TWM_BIT;
                     phase <= 2'h0;
                     bit_idx <= 4'h0;
                  end
               end
            end
            twm_pkg::TWM_BIT: begin
               if (step) begin
                  phase <= phase + 2'h1;
                  if (phase == 2'h2 && bit_idx == `TWM_BIT_LAST && sda_seen) begin
                     got_nack <= 1'b1;
                  end
                  if (phase == 2'h3) begin
                     if (bit_idx != `TWM_BIT_LAST) begin
                        bit_idx <= bit_idx + 4'h1;
                        if (bit_idx != 4'h7) begin
                           shreg <= {shreg[6:0], 1'b0};
                        end
                     end else if (ack_error || !more || !tx_valid) begin
                        state <= twm_pkg::TWM_STOP;
                     end else begin
                        bit_idx <= 4'h0;
                        shreg <= tx_data;
                        more <= !tx_last;
                     end
                  end
               end
            end
            twm_pkg::TWM_STOP: begin
               if (step) begin
                  phase <= phase + 2'h1;
                  if (phase == 2'h3) begin
                     state <= twm_pkg::TWM_IDLE;
                  end
               end
            end
            default: begin
               state <= twm_pkg::TWM_IDLE;
            end
         endcase
      end
   end

   // Sticky error: a new miss wins over a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ack_error <= 1'b0;
      end else if (clk_en) begin
         if (got_nack) begin
            ack_error <= 1'b1;
         end else if (error_clear) begin
            ack_error <= 1'b0;
         end
      end
   end

   // Line levels decided per state and phase
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         scl_low <= 1'b0;
         sda_low <= 1'b0;
      end else if (clk_en) begin
         case (state)
            twm_pkg::TWM_START: begin
               scl_low <= (phase == 2'h1) && step;
               sda_low <= 1'b1;
            end
            twm_pkg::TWM_BIT: begin
               scl_low <= !(phase == 2'h1 || phase == 2'h2);
               if (phase == 2'h0) begin
                  sda_low <= (bit_idx != `TWM_BIT_LAST) && !shreg[7];
               end
            end
            twm_pkg::TWM_STOP: begin
               scl_low <= (phase == 2'h0);
               // Data low in quarters 0-1, released in quarter 2 with clock high, then idle gap
               sda_low <= (phase == 2'h0) || (phase == 2'h1);
            end
            default: begin
               scl_low <= 1'b0;
               sda_low <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain emulation: drive low or release
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_low;
   assign sda_oe = sda_low;
   assign busy = (state != twm_pkg::TWM_IDLE);
   assign tx_ready = (state == twm_pkg::TWM_BIT) && step && (phase == 2'h3)
      && (bit_idx == `TWM_BIT_LAST) && more && !ack_error && !got_nack;

   // Assertions
   // Length of the current released-clock stretch, saturating
   logic [7:0] hi_run;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hi_run <= 8'h00;
      end else if (clk_en) begin
         if (scl_oe) begin
            hi_run <= 8'h00;
         end else if (hi_run != 8'hFF) begin
            hi_run <= hi_run + 8'h01;
         end
      end
   end
   sequence s_start_edge;
      !sda_oe && !scl_oe ##1 sda_oe && !scl_oe;
   endsequence

   a_idle_lines_free: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == twm_pkg::TWM_IDLE && $past(state) == twm_pkg::TWM_IDLE)
      |-> !scl_oe && !sda_oe)
      else $error("lines not released while idle");
   a_start_cond: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(state == twm_pkg::TWM_START) |-> ##1 sda_oe && !scl_oe)
      else $error("start not data low with clock high");
   a_start_seq: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_start_edge |-> state == twm_pkg::TWM_START)
      else $error("data fell with clock high outside start");
   a_stop_cond: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(sda_oe) && !scl_oe |-> state == twm_pkg::TWM_STOP || state == twm_pkg::TWM_IDLE
      || (state == twm_pkg::TWM_BIT && bit_idx == `TWM_BIT_LAST))
      else $error("data rose with clock high outside stop");
   a_data_stable: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state == twm_pkg::TWM_BIT && !scl_oe && !$past(scl_oe) && bit_idx != `TWM_BIT_LAST
      |-> $stable(sda_oe))
      else $error("data moved while clock high");
   a_ack_released: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state == twm_pkg::TWM_BIT && bit_idx == `TWM_BIT_LAST && phase != 2'h0 |-> !sda_oe)
      else $error("master drove the acknowledge slot");
   a_error_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ack_error && !error_clear |=> ack_error)
      else $error("error flag dropped without clear");
   a_nack_stops: assert property (@(posedge clk_sys) disable iff (sys_rst)
      got_nack |-> ##[1:600] state == twm_pkg::TWM_STOP)
      else $error("no stop after missing acknowledge");
   a_rate_limit: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(scl_oe) |-> ##1 scl_oe [*2])
      else $error("serial clock low phase too short");
   a_quarter_ok: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(scl_oe) && state == twm_pkg::TWM_BIT |-> 2 * hi_run >= `TWM_MIN_PERIOD_CYC)
      else $error("serial clock high phase too short");
endmodule // twm_master

// [sim/twm_slave_model.sv]
// Behavioural two-wire slave that collects bytes and answers acknowledge
`timescale 1ns/100ps
module twm_slave_model (
   // Bus levels
   input wire logic scl,
   input wire logic sda,
   // Control
   input wire logic nack,
   // Data pull-down
   output logic sda_oe
);
   logic [7:0] sh;
   logic [7:0] rx_mem [0:31];
   int bitc = 0;
   int rx_cnt = 0;
   int start_cnt = 0;
   int stop_cnt = 0;
   realtime t0 = 0;
   realtime per = 0;
   initial sda_oe = 1'h0;
   always @(negedge sda) if (scl === 1'h1) begin
      start_cnt++;
      bitc = 0;
   end
   always @(posedge sda) if (scl === 1'h1) stop_cnt++;
   // Bits are taken while clock is high
   always @(posedge scl) begin
      sh = {sh[6:0], sda};
      if (bitc == 7 && rx_cnt < 32) rx_mem[rx_cnt++] = sh;
      bitc++;
      if (bitc == 1) t0 = $realtime;
      if (bitc == 2) per = $realtime - t0;
   end
   // Acknowledge held low through the ninth clock, then released
   always @(negedge scl) begin
      if (bitc == 8) sda_oe = !nack;
      if (bitc == 9) begin
         sda_oe = 1'h0;
         bitc = 0;
      end
   end
endmodule // twm_slave_model

// [sim/tb_top.sv]
// Self-checking bench of the two-wire write master
`timescale 1ns/100ps
module tb_top;
   logic clk_sys = 1'h0;
   logic sys_rst = 1'h1;
   logic start_req = 1'h0;
   logic tx_valid = 1'h0;
   logic tx_last = 1'h0;
   logic error_clear = 1'h0;
   logic clk_en = 1'h1;
   logic nack = 1'h0;
   logic [6:0] slave_addr = 7'h00;
   logic [7:0] tx_data = 8'h00;
   logic tx_ready, busy, ack_error, scl_oe, sda_oe, s_oe, scl_out, sda_out;
   logic [7:0] dat [0:3];
   int fail_count = 0;
   int compares = 0;
   int seed = 32'hF947CED9;
   // Pulled-up lines: the driven level shows only while the enable is high
   wire scl_w = scl_oe ? scl_out : 1'h1;
   wire sda_w = (sda_oe ? sda_out : 1'h1) & ~s_oe;
   twm_master twm_master_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
      .start_req(start_req), .slave_addr(slave_addr), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .busy(busy),
      .ack_error(ack_error), .error_clear(error_clear), .scl_in(scl_w), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
   twm_slave_model twm_slave_model_i (.scl(scl_w), .sda(sda_w), .nack(nack), .sda_oe(s_oe));
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic end_sim();
      if (fail_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // Runs one transfer; the byte is swapped one edge after tx_ready was seen
   task automatic xfer(input logic [6:0] a, input int n);
      int k;
      int g;
      logic seen;
      k = 0;
      g = 0;
      seen = 1'h0;
      @(negedge clk_sys);
      slave_addr = a;
      tx_data = dat[0];
      tx_valid = 1'h1;
      tx_last = (n == 1);
      start_req = 1'h1;
      @(negedge clk_sys);
      start_req = 1'h0;
      while (busy === 1'h1 && g < 20000) begin
         if (seen) begin
            k++;
            tx_data = dat[k];
            tx_last = (k == n - 1);
            tx_valid = (k < n);
         end
         seen = (tx_ready === 1'h1);
         @(negedge clk_sys);
         g++;
      end
      tx_valid = 1'h0;
      if (g >= 20000) begin
         fail_count++;
         end_sim();
      end
   endtask
   function automatic logic [7:0] addr_byte(input logic [6:0] a);
      return {a, 1'h0};
   endfunction
   initial begin
      int n;
      int r0;
      int s0;
      int q0;
      logic [6:0] a;
      repeat (5) @(negedge clk_sys);
      sys_rst = 1'h0;
      @(negedge clk_sys);
      check({busy, scl_w, sda_w}, 32'h3);
      for (int t = 0; t < 5; t++) begin
         a = (t == 0) ? 7'h7F : (t == 1) ? 7'h00 : 7'($random(seed));
         n = (t < 2) ? 3 : 1 + ($unsigned($random(seed)) % 3);
         for (int i = 0; i < 4; i++) begin
            dat[i] = (t == 0) ? 8'hFF : (t == 1) ? 8'h00 : 8'($random(seed));
         end
         r0 = twm_slave_model_i.rx_cnt;
         s0 = twm_slave_model_i.stop_cnt;
         q0 = twm_slave_model_i.start_cnt;
         xfer(a, n);
         check(twm_slave_model_i.rx_cnt - r0, n + 1);
         check(twm_slave_model_i.rx_mem[r0], addr_byte(a));
         for (int i = 0; i < n; i++) check(twm_slave_model_i.rx_mem[r0 + 1 + i], dat[i]);
         check(twm_slave_model_i.stop_cnt - s0, 1);
         check(twm_slave_model_i.start_cnt - q0, 1);
         check({ack_error, scl_w, sda_w}, 32'h3);
         check(int'(twm_slave_model_i.per), 6300);
      end
      nack = 1'h1;
      r0 = twm_slave_model_i.rx_cnt;
      s0 = twm_slave_model_i.stop_cnt;
      xfer(7'h55, 2);
      nack = 1'h0;
      check(twm_slave_model_i.rx_cnt - r0, 1);
      check(twm_slave_model_i.stop_cnt - s0, 1);
      check(ack_error, 1'h1);
      repeat (20) @(negedge clk_sys);
      check({ack_error, busy}, 32'h2);
      // A pending error still blocks data bytes: address only, then stop
      r0 = twm_slave_model_i.rx_cnt;
      s0 = twm_slave_model_i.stop_cnt;
      xfer(7'h2A, 2);
      check(twm_slave_model_i.rx_cnt - r0, 1);
      check(twm_slave_model_i.stop_cnt - s0, 1);
      check(ack_error, 1'h1);
      error_clear = 1'h1;
      @(negedge clk_sys);
      error_clear = 1'h0;
      @(negedge clk_sys);
      check(ack_error, 1'h0);
      // Clock enable low freezes the master: a start request is not taken
      clk_en = 1'h0;
      start_req = 1'h1;
      repeat (3) @(negedge clk_sys);
      check({busy, scl_w, sda_w}, 32'h3);
      start_req = 1'h0;
      clk_en = 1'h1;
      @(negedge clk_sys);
      check({busy, scl_w, sda_w}, 32'h3);
      end_sim();
   end
endmodule // tb_top
